/* File: verilog/sspc_top.sv */
/*
 Sleep and shutdown power controller: mode machine, sleep measurement pacing,
 wake comparator, shutdown thresholds and auto re-shutdown, with a register port.
 Assumes measurement results, communication and wake events come from clk_sys logic.
*/
`timescale 1ns/1ps
`default_nettype none
module sspc_top
    import sspc_pkg::*;
#(
    parameter int P_MS_CYCLES = MS_TICK_CYC,
    parameter int P_MS_PER_S  = MS_PER_SEC
)(
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     nrst,
    // Register port
    input  wire logic [3:0]               reg_addr,
    input  wire logic [15:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [15:0]              reg_rdata,
    // Measurement results
    input  wire logic                     meas_valid,
    input  wire logic [N_CELLS*16-1:0]    cell_sense_input,
    input  wire logic [15:0]              stack_mv,
    input  wire logic [7:0]               int_temp_c,
    input  wire logic signed [15:0]       current_user,
    // Wake comparator and events
    input  wire logic signed [15:0]       sense_uv,
    input  wire logic                     comm_valid,
    input  wire logic                     wake_from_shutdown,
    // Power control
    output logic [1:0]                    power_mode,
    output logic                          sleep_meas_req
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0]  ivl_reg,   ivl_next;
    logic [7:0]  wake_reg,  wake_next;
    logic [15:0] cthr_reg,  cthr_next;
    logic [15:0] sthr_reg,  sthr_next;
    logic [7:0]  tthr_reg,  tthr_next;
    logic [7:0]  amin_reg,  amin_next;
    logic [15:0] scur_reg,  scur_next;
    logic [4:0]  mask_reg,  mask_next;
    logic        slp_en_reg, slp_en_next;
    logic [15:0] rdata_next;
    sspc_mode_t  mode_reg,  mode_next;
    logic        req_next;
    logic [19:0] pace_reg,  pace_next;
    logic        cell_c_reg, cell_c_next;
    logic        stk_c_reg,  stk_c_next;
    logic        armed_reg,  armed_next;
    logic [7:0]  asec_reg,  asec_next;
    logic [7:0]  amin_cnt_reg, amin_cnt_next;
    logic        ms_tick;
    logic        sec_tick;
    logic        cell_exp;
    logic        stk_exp;
    logic        cell_hit;
    logic        wake_hit;
    logic        cur_over;
    logic [19:0] pace_end;
    logic        shut_now;

    sspc_tick_div #(.MS_CYCLES(P_MS_CYCLES), .MS_PER_S(P_MS_PER_S)) u_div (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .ms_tick  (ms_tick),
        .sec_tick (sec_tick)
    );

    sspc_persist #(.DELAY_S(SHUT_DELAY_S)) u_cell_dly (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .cond     (cell_c_reg),
        .sec_tick (sec_tick),
        .expired  (cell_exp)
    );

    sspc_persist #(.DELAY_S(SHUT_DELAY_S)) u_stack_dly (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .cond     (stk_c_reg),
        .sec_tick (sec_tick),
        .expired  (stk_exp)
    );

    // ----------------------------------------
    // Comparisons
    // ----------------------------------------
    always_comb
    begin
        cell_hit = 1'b0;
        for (int i = 0; i < N_CELLS; i++)
        begin
            if (mask_reg[i] && ($signed(cell_sense_input[i*16 +: 16]) <= $signed(cthr_reg)))
            begin
                cell_hit = 1'b1;
            end
        end
    end

    assign wake_hit = sspc_abs(sense_uv) > 16'(wake_reg * WAKE_STEP_UV);
    assign cur_over = sspc_abs(current_user) > scur_reg;
    assign pace_end = (ivl_reg == 8'h00) ? 20'(SLEEP_FAST_MS - 1)
                                         : 20'(ivl_reg * P_MS_PER_S - 1);
    assign shut_now = cell_exp || stk_exp
                   || (meas_valid && tthr_reg != 8'h00 && int_temp_c >= tthr_reg)
                   || (armed_reg && amin_cnt_reg >= amin_reg && amin_reg != 8'h00);

    // ----------------------------------------
    // Registers and bus
    // ----------------------------------------
    always_comb
    begin
        ivl_next    = ivl_reg;
        wake_next   = wake_reg;
        cthr_next   = cthr_reg;
        sthr_next   = sthr_reg;
        tthr_next   = tthr_reg;
        amin_next   = amin_reg;
        scur_next   = scur_reg;
        mask_next   = mask_reg;
        slp_en_next = slp_en_reg;
        rdata_next  = 16'h0000;
        if (reg_wr)
        begin
            case (reg_addr)
                OFF_SLEEP_IVL: ivl_next    = reg_wdata[7:0];
                OFF_WAKE_THR:  wake_next   = sspc_clamp(reg_wdata[7:0], WAKE_SET_MIN,
                                                        WAKE_SET_MAX);
                OFF_CELL_THR:  cthr_next   = reg_wdata;
                OFF_STACK_THR: sthr_next   = reg_wdata;
                OFF_TEMP_THR:  tthr_next   = sspc_clamp(reg_wdata[7:0], 8'h00, TEMP_SET_MAX);
                OFF_AUTO_MIN:  amin_next   = reg_wdata[7:0];
                OFF_SLEEP_CUR: scur_next   = {1'b0, reg_wdata[14:0]};
                OFF_CELL_MASK: mask_next   = reg_wdata[4:0];
                OFF_CTRL:      slp_en_next = reg_wdata[0];
                default:       ;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                OFF_SLEEP_IVL: rdata_next = {8'h00, ivl_reg};
                OFF_WAKE_THR:  rdata_next = {8'h00, wake_reg};
                OFF_CELL_THR:  rdata_next = cthr_reg;
                OFF_STACK_THR: rdata_next = sthr_reg;
                OFF_TEMP_THR:  rdata_next = {8'h00, tthr_reg};
                OFF_AUTO_MIN:  rdata_next = {8'h00, amin_reg};
                OFF_SLEEP_CUR: rdata_next = scur_reg;
                OFF_CELL_MASK: rdata_next = {11'h000, mask_reg};
                OFF_CTRL:      rdata_next = {15'h0000, slp_en_reg};
                OFF_STATUS:    rdata_next = {11'h000, stk_c_reg, cell_c_reg, armed_reg,
                                             2'(mode_reg)};
                default:       rdata_next = 16'h0000;
            endcase
        end
    end

    // ----------------------------------------
    // Mode machine and timers
    // ----------------------------------------
    always_comb
    begin
        mode_next     = mode_reg;
        req_next      = 1'b0;
        pace_next     = pace_reg;
        cell_c_next   = cell_c_reg;
        stk_c_next    = stk_c_reg;
        armed_next    = armed_reg;
        asec_next     = asec_reg;
        amin_cnt_next = amin_cnt_reg;
        if (meas_valid)
        begin
            cell_c_next = (cthr_reg != 16'h0000) && cell_hit;
            stk_c_next  = (sthr_reg != 16'h0000) && (stack_mv <= sthr_reg);
        end
        if (armed_reg && sec_tick)
        begin
            if (asec_reg >= 8'(SEC_PER_MIN - 1))
            begin
                asec_next     = 8'h00;
                amin_cnt_next = amin_cnt_reg + 8'h01;
            end
            else
            begin
                asec_next = asec_reg + 8'h01;
            end
        end
        if (comm_valid || (meas_valid && cur_over))
        begin
            armed_next = 1'b0;
        end
        case (mode_reg)
            MODE_NORMAL:
            begin
                pace_next = 20'h00000;
                if (shut_now)
                begin
                    mode_next = MODE_SHUTDOWN;
                end
                else if (slp_en_reg && !cur_over && !wake_hit)
                begin
                    mode_next = MODE_SLEEP;
                end
            end
            MODE_SLEEP:
            begin
                if (ms_tick)
                begin
                    if (pace_reg >= pace_end)
                    begin
                        pace_next = 20'h00000;
                        req_next  = 1'b1;
                    end
                    else
                    begin
                        pace_next = pace_reg + 20'h00001;
                    end
                end
                if (shut_now)
                begin
                    mode_next = MODE_SHUTDOWN;
                end
                else if (wake_hit || (meas_valid && cur_over) || !slp_en_reg)
                begin
                    mode_next = MODE_NORMAL;
                end
            end
            MODE_SHUTDOWN:
            begin
                cell_c_next = 1'b0;
                stk_c_next  = 1'b0;
                armed_next  = 1'b0;
                if (wake_from_shutdown)
                begin
                    mode_next     = MODE_NORMAL;
                    armed_next    = (amin_reg != 8'h00);
                    asec_next     = 8'h00;
                    amin_cnt_next = 8'h00;
                end
            end
            default:
            begin
                mode_next = MODE_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ivl_reg        <= RST_SLEEP_IVL;
            wake_reg       <= RST_WAKE_THR;
            cthr_reg       <= RST_CELL_THR;
            sthr_reg       <= RST_STACK_THR;
            tthr_reg       <= RST_TEMP_THR;
            amin_reg       <= RST_AUTO_MIN;
            scur_reg       <= RST_SLEEP_CUR;
            mask_reg       <= RST_CELL_MASK;
            slp_en_reg     <= 1'b0;
            reg_rdata      <= 16'h0000;
            mode_reg       <= MODE_NORMAL;
            sleep_meas_req <= 1'b0;
            power_mode     <= 2'h0;
            pace_reg       <= 20'h00000;
            cell_c_reg     <= 1'b0;
            stk_c_reg      <= 1'b0;
            armed_reg      <= 1'b0;
            asec_reg       <= 8'h00;
            amin_cnt_reg   <= 8'h00;
        end
        else
        begin
            ivl_reg        <= ivl_next;
            wake_reg       <= wake_next;
            cthr_reg       <= cthr_next;
            sthr_reg       <= sthr_next;
            tthr_reg       <= tthr_next;
            amin_reg       <= amin_next;
            scur_reg       <= scur_next;
            mask_reg       <= mask_next;
            slp_en_reg     <= slp_en_next;
            reg_rdata      <= rdata_next;
            mode_reg       <= mode_next;
            sleep_meas_req <= req_next;
            power_mode     <= 2'(mode_next);
            pace_reg       <= pace_next;
            cell_c_reg     <= cell_c_next;
            stk_c_reg      <= stk_c_next;
            armed_reg      <= armed_next;
            asec_reg       <= asec_next;
            amin_cnt_reg   <= amin_cnt_next;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_req_only_sleep: assert property (sleep_meas_req |-> $past(mode_reg) == MODE_SLEEP)
        else $error("sleep measurement outside sleep");
    chk_fast_pace: assert property ((mode_reg == MODE_SLEEP && ivl_reg == 8'h00 && ms_tick
        && pace_reg == 20'(SLEEP_FAST_MS - 1)) |=> sleep_meas_req)
        else $error("250 ms pacing missed");
    chk_wake_range: assert property (wake_reg >= WAKE_SET_MIN && wake_reg <= WAKE_SET_MAX)
        else $error("wake setting out of range");
    chk_wake_exit: assert property ((mode_reg == MODE_SLEEP && wake_hit && !shut_now)
        |=> mode_reg == MODE_NORMAL)
        else $error("wake comparator did not exit sleep");
    chk_cell_off: assert property ((cthr_reg == 16'h0000 && meas_valid) |=> !cell_c_reg)
        else $error("cell check active with zero threshold");
    chk_stack_off: assert property ((sthr_reg == 16'h0000 && meas_valid) |=> !stk_c_reg)
        else $error("stack check active with zero threshold");
    chk_temp_shut: assert property ((meas_valid && tthr_reg != 8'h00 && int_temp_c >= tthr_reg
        && mode_reg != MODE_SHUTDOWN) |=> mode_reg == MODE_SHUTDOWN)
        else $error("temperature shutdown missed");
    chk_auto_off: assert property ((mode_reg == MODE_SHUTDOWN && wake_from_shutdown
        && amin_reg == 8'h00) |=> !armed_reg)
        else $error("auto shutdown armed while disabled");
    chk_cancel: assert property ((comm_valid && mode_reg != MODE_SHUTDOWN) |=> !armed_reg)
        else $error("communication did not cancel auto shutdown");
    chk_cur_cancel: assert property ((meas_valid && cur_over && mode_reg != MODE_SHUTDOWN)
        |=> !armed_reg)
        else $error("current did not cancel auto shutdown");
    chk_restart: assert property ($fell(cell_c_reg) |=> !cell_exp [*2])
        else $error("cell delay did not restart");

    cov_sleep_entry: cover property (mode_reg == MODE_NORMAL ##1 mode_reg == MODE_SLEEP);
    cov_cell_shut:   cover property (cell_exp ##1 mode_reg == MODE_SHUTDOWN);
    cov_auto_shut:   cover property (armed_reg ##1 mode_reg == MODE_SHUTDOWN);

endmodule
`default_nettype wire

/* File: verilog/sspc_pkg.sv */
/*
 Constants, types and helpers shared by the sleep and shutdown power controller.
 Assumes one 200 MHz system clock and measurement results from the same clock domain.
*/
// Function
// - Sleep measurements repeat every configured whole second
// - Interval zero gives 250 ms measurements
// - Wake threshold is setting times 500 uV
// - Sleep exits when current magnitude exceeds wake threshold
// - Cell at threshold shuts down after 10 s
// - Only connected cell inputs are checked
// - Zero cell threshold disables cell shutdown
// - Stack at threshold shuts down after 10 s
// - Internal temperature at threshold shuts down
// - Auto re-shutdown after configured minutes post wake
// - Communication or current cancels pending auto shutdown
// - Zero minutes disables auto re-shutdown
// - Sleep current threshold blocks and exits sleep
`default_nettype none
package sspc_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_FREQ_KHZ  = 200000;
    localparam int TICK_MS       = 1;
    localparam int MS_TICK_CYC   = CLK_FREQ_KHZ * TICK_MS;
    localparam int MS_PER_SEC    = 1000;
    localparam int SLEEP_FAST_MS = 250;
    localparam int SHUT_DELAY_S  = 10;
    localparam int SEC_PER_MIN   = 60;
    localparam int WAKE_STEP_UV  = 500;
    localparam int N_CELLS       = 5;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [3:0] OFF_SLEEP_IVL  = 4'h0;
    localparam logic [3:0] OFF_WAKE_THR   = 4'h1;
    localparam logic [3:0] OFF_CELL_THR   = 4'h2;
    localparam logic [3:0] OFF_STACK_THR  = 4'h3;
    localparam logic [3:0] OFF_TEMP_THR   = 4'h4;
    localparam logic [3:0] OFF_AUTO_MIN   = 4'h5;
    localparam logic [3:0] OFF_SLEEP_CUR  = 4'h6;
    localparam logic [3:0] OFF_CELL_MASK  = 4'h7;
    localparam logic [3:0] OFF_CTRL       = 4'h8;
    localparam logic [3:0] OFF_STATUS     = 4'h9;

    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [7:0]  RST_SLEEP_IVL = 8'h05;
    localparam logic [7:0]  RST_WAKE_THR  = 8'h01;
    localparam logic [15:0] RST_CELL_THR  = 16'h0000;
    localparam logic [15:0] RST_STACK_THR = 16'h0000;
    localparam logic [7:0]  RST_TEMP_THR  = 8'h00;
    localparam logic [7:0]  RST_AUTO_MIN  = 8'h00;
    localparam logic [15:0] RST_SLEEP_CUR = 16'h0040;
    localparam logic [4:0]  RST_CELL_MASK = 5'h1F;
    localparam logic [7:0]  WAKE_SET_MIN  = 8'h01;
    localparam logic [7:0]  WAKE_SET_MAX  = 8'h0A;
    localparam logic [7:0]  TEMP_SET_MAX  = 8'h96;

    typedef enum logic [1:0] {MODE_NORMAL, MODE_SLEEP, MODE_SHUTDOWN} sspc_mode_t;

    // Magnitude of a signed 16-bit value
    function automatic logic [15:0] sspc_abs(input logic signed [15:0] v);
        sspc_abs = v[15] ? 16'(-v) : 16'(v);
    endfunction

    // Clamp a setting into a range
    function automatic logic [7:0] sspc_clamp(input logic [7:0] v, input logic [7:0] lo,
                                              input logic [7:0] hi);
        sspc_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

endpackage
`default_nettype wire

/* File: verilog/sspc_tick_div.sv */
/*
 Divider making one-cycle millisecond and second enables from the system clock.
 Assumes a free-running clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module sspc_tick_div
    import sspc_pkg::*;
#(
    parameter int MS_CYCLES = MS_TICK_CYC,
    parameter int MS_PER_S  = MS_PER_SEC
)(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Enables
    output logic      ms_tick,
    output logic      sec_tick
);

    logic [31:0] cyc_reg;
    logic [31:0] cyc_next;
    logic [31:0] ms_reg;
    logic [31:0] ms_next;
    logic        ms_tick_next;
    logic        sec_tick_next;

    always_comb
    begin
        cyc_next      = cyc_reg + 32'h1;
        ms_next       = ms_reg;
        ms_tick_next  = 1'b0;
        sec_tick_next = 1'b0;
        if (cyc_reg >= 32'(MS_CYCLES - 1))
        begin
            cyc_next     = 32'h0;
            ms_tick_next = 1'b1;
            ms_next      = ms_reg + 32'h1;
            if (ms_reg >= 32'(MS_PER_S - 1))
            begin
                ms_next       = 32'h0;
                sec_tick_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cyc_reg  <= 32'h0;
            ms_reg   <= 32'h0;
            ms_tick  <= 1'b0;
            sec_tick <= 1'b0;
        end
        else
        begin
            cyc_reg  <= cyc_next;
            ms_reg   <= ms_next;
            ms_tick  <= ms_tick_next;
            sec_tick <= sec_tick_next;
        end
    end

endmodule
`default_nettype wire

/* File: verilog/sspc_persist.sv */
/*
 Persistence timer: fires when a condition has held for DELAY_S whole seconds.
 Assumes cond is a registered level and sec_tick a one-cycle enable.
*/
`timescale 1ns/1ps
`default_nettype none
module sspc_persist
    import sspc_pkg::*;
#(
    parameter int DELAY_S = SHUT_DELAY_S
)(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic nrst,
    // Condition and time base
    input  wire logic cond,
    input  wire logic sec_tick,
    // Result
    output logic      expired
);

    logic [7:0] sec_reg;
    logic [7:0] sec_next;
    logic       expired_next;

    always_comb
    begin
        sec_next     = sec_reg;
        expired_next = 1'b0;
        if (!cond)
        begin
            sec_next = 8'h00;
        end
        else if (sec_tick)
        begin
            if (sec_reg >= 8'(DELAY_S - 1))
            begin
                expired_next = 1'b1;
                sec_next     = 8'h00;
            end
            else
            begin
                sec_next = sec_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            sec_reg <= 8'h00;
            expired <= 1'b0;
        end
        else
        begin
            sec_reg <= sec_next;
            expired <= expired_next;
        end
    end

endmodule
`default_nettype wire

/* File: dv/tb.sv */
/*
 Self-checking bench for the sleep and shutdown power controller.
 Assumes tick parameters of 4, so one second is 16 clk_sys cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
    import sspc_pkg::*;
;
    logic                    clk_sys, nrst, reg_wr, reg_rd, meas_valid;
    logic                    comm_valid, wake_from_shutdown, sleep_meas_req;
    logic [3:0]              reg_addr;
    logic [15:0]             reg_wdata, reg_rdata, stack_mv, rd_val;
    logic [N_CELLS*16-1:0]   cell_sense_input;
    logic [7:0]              int_temp_c;
    logic signed [15:0]      current_user, sense_uv;
    logic [1:0]              power_mode;
    int                      fail_count, samples_checked, i, per;
    // Rows: write flag, index, write data, expected read
    logic [36:0]             rows [16] = '{
        {1'h0, 4'h0, 16'h0000, 16'h0005}, {1'h0, 4'h1, 16'h0000, 16'h0001},
        {1'h0, 4'h2, 16'h0000, 16'h0000}, {1'h0, 4'h3, 16'h0000, 16'h0000},
        {1'h0, 4'h4, 16'h0000, 16'h0000}, {1'h0, 4'h5, 16'h0000, 16'h0000},
        {1'h0, 4'h6, 16'h0000, 16'h0040}, {1'h0, 4'h7, 16'h0000, 16'h001F},
        {1'h0, 4'hF, 16'h0000, 16'h0000}, {1'h1, 4'h1, 16'h0000, 16'h0001},
        {1'h1, 4'h1, 16'h000B, 16'h000A}, {1'h1, 4'h1, 16'h0002, 16'h0002},
        {1'h1, 4'h4, 16'h00C8, 16'h0096}, {1'h1, 4'h4, 16'h0032, 16'h0032},
        {1'h1, 4'h9, 16'h001F, 16'h0000}, {1'h1, 4'h0, 16'h0001, 16'h0001}};

    sspc_top #(.P_MS_CYCLES(4), .P_MS_PER_S(4)) u_sspc_top (
        .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .meas_valid(meas_valid),
        .cell_sense_input(cell_sense_input), .stack_mv(stack_mv), .int_temp_c(int_temp_c),
        .current_user(current_user), .sense_uv(sense_uv), .comm_valid(comm_valid),
        .wake_from_shutdown(wake_from_shutdown), .power_mode(power_mode),
        .sleep_meas_req(sleep_meas_req));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        d = reg_rdata;
    endtask

    task automatic meas(input logic [15:0] c0, c4, stk, input logic [7:0] t,
                        input logic [15:0] cur);
        @(posedge clk_sys);
        cell_sense_input <= {c4, {3{16'h0DAC}}, c0};
        stack_mv         <= stk;
        int_temp_c       <= t;
        current_user     <= cur;
        meas_valid       <= 1'h1;
        @(posedge clk_sys);
        meas_valid <= 1'h0;
    endtask

    task automatic event_pulse(input logic wake);
        @(posedge clk_sys);
        if (wake)
            wake_from_shutdown <= 1'h1;
        else
            comm_valid <= 1'h1;
        @(posedge clk_sys);
        wake_from_shutdown <= 1'h0;
        comm_valid         <= 1'h0;
    endtask

    task automatic mode_after(input int n, input logic [1:0] exp, input string what);
        repeat (n) @(posedge clk_sys);
        #1;
        check(what, {14'h0000, power_mode}, {14'h0000, exp});
    endtask

    // Cycles between two measurement requests, after skipping one
    task automatic period(output int n);
        int guard;
        n = 0;
        repeat (2)
        begin
            guard = 0;
            do
            begin
                @(posedge clk_sys);
                #1;
                guard++;
            end while (sleep_meas_req !== 1'h1 && guard < 3000);
            n = guard;
        end
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------
    // Clock, watchdog and sequence
    // ----------------------------------------
    initial
    begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        tally_and_finish;
    end

    initial
    begin
        nrst = 1'h0; reg_wr = 1'h0; reg_rd = 1'h0; reg_addr = 4'h0; reg_wdata = 16'h0000;
        meas_valid = 1'h0; comm_valid = 1'h0; wake_from_shutdown = 1'h0;
        cell_sense_input = '0; stack_mv = 16'h0000; int_temp_c = 8'h00;
        current_user = 16'h0000; sense_uv = 16'h0000;
        fail_count = 0; samples_checked = 0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'h1;
        for (i = 0; i < 16; i++)
        begin
            if (rows[i][36])
                wr(rows[i][35:32], rows[i][31:16]);
            rd(rows[i][35:32], rd_val);
            check("register", rd_val, rows[i][15:0]);
        end
        @(posedge clk_sys);
        #1;
        check("rdata idle", reg_rdata, 16'h0000);
        // Sleep pacing, one second then the fast rate
        wr(4'h8, 16'h0001);
        mode_after(3, 2'h1, "sleep entry");
        period(per);
        check("sleep period", per[15:0], 16'h0010);
        wr(4'h0, 16'h0000);
        period(per);
        check("fast period", per[15:0], 16'h03E8);
        // Wake comparator at setting 2, both directions
        @(posedge clk_sys);
        sense_uv <= 16'sd1000;
        mode_after(3, 2'h1, "wake at limit");
        @(posedge clk_sys);
        sense_uv <= -16'sd1001;
        mode_after(3, 2'h0, "wake discharge");
        @(posedge clk_sys);
        sense_uv <= 16'sd0;
        mode_after(3, 2'h1, "sleep again");
        @(posedge clk_sys);
        sense_uv <= 16'sd1001;
        mode_after(3, 2'h0, "wake charge");
        @(posedge clk_sys);
        sense_uv <= 16'sd0;
        mode_after(3, 2'h1, "sleep again");
        // Sleep current threshold
        meas(16'h0000, 16'h0000, 16'h0000, 8'h00, 16'h0040);
        mode_after(3, 2'h1, "current at limit");
        meas(16'h0000, 16'h0000, 16'h0000, 8'h00, -16'sd65);
        mode_after(3, 2'h0, "current over");
        mode_after(20, 2'h0, "entry blocked");
        meas(16'h0000, 16'h0000, 16'h0000, 8'h00, 16'h0000);
        mode_after(3, 2'h1, "sleep after current");
        wr(4'h8, 16'h0000);
        mode_after(3, 2'h0, "sleep disabled");
        // Temperature shutdown, zero cell and stack limits disabled
        meas(16'h0000, 16'h0000, 16'h0000, 8'h31, 16'h0000);
        mode_after(3, 2'h0, "temp below");
        meas(16'h0000, 16'h0000, 16'h0000, 8'h32, 16'h0000);
        mode_after(3, 2'h2, "temp reached");
        rd(4'h9, rd_val);
        check("status", rd_val, 16'h0002);
        wr(4'h4, 16'h0000);
        event_pulse(1'h1);
        mode_after(3, 2'h0, "woken");
        meas(16'h0000, 16'h0000, 16'h0000, 8'h00, 16'h0000);
        mode_after(1100, 2'h0, "no auto shutdown");
        // Cell shutdown with unused input and a restarted delay
        wr(4'h2, 16'h0BB8);
        wr(4'h7, 16'h000F);
        meas(16'h0DAC, 16'h07D0, 16'h4E20, 8'h00, 16'h0000);
        mode_after(200, 2'h0, "unused cell");
        meas(16'h0BB8, 16'h0DAC, 16'h4E20, 8'h00, 16'h0000);
        repeat (100) @(posedge clk_sys);
        meas(16'h0BB9, 16'h0DAC, 16'h4E20, 8'h00, 16'h0000);
        meas(16'h0BB8, 16'h0DAC, 16'h4E20, 8'h00, 16'h0000);
        mode_after(130, 2'h0, "cell delay restart");
        mode_after(60, 2'h2, "cell shutdown");
        // Stack shutdown
        wr(4'h2, 16'h0000);
        wr(4'h3, 16'h2710);
        meas(16'h0DAC, 16'h0DAC, 16'h4E20, 8'h00, 16'h0000);
        event_pulse(1'h1);
        meas(16'h0DAC, 16'h0DAC, 16'h2328, 8'h00, 16'h0000);
        mode_after(130, 2'h0, "stack pending");
        mode_after(60, 2'h2, "stack shutdown");
        // Auto re-shutdown after one minute, then cancelled
        wr(4'h3, 16'h0000);
        wr(4'h5, 16'h0001);
        meas(16'h0DAC, 16'h0DAC, 16'h4E20, 8'h00, 16'h0000);
        event_pulse(1'h1);
        mode_after(900, 2'h0, "auto pending");
        mode_after(100, 2'h2, "auto shutdown");
        event_pulse(1'h1);
        repeat (300) @(posedge clk_sys);
        event_pulse(1'h0);
        mode_after(900, 2'h0, "auto cancelled");
        tally_and_finish;
    end
endmodule
`default_nettype wire
